/* File: common/pwrwk_pkg.sv */
`default_nettype none
package pwrwk_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STAT = 8'h04;
  localparam logic [7:0] OFS_WKCTL = 8'h08;
  localparam logic [7:0] OFS_WIN = 8'h0c;
  localparam logic [7:0] OFS_PSC = 8'h10;
  localparam logic [7:0] OFS_IRQ_ST = 8'h14;
  localparam logic [7:0] OFS_IRQ_CLR = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN = 8'h1c;
  // Field positions
  localparam int POS_DDS = 1;
  localparam int POS_MON_EN = 4;
  localparam int POS_THR = 5;
  localparam int POS_FLAG = 2;
  localparam int POS_WK_EN = 1;
  localparam int POS_IRQ_WAKE = 0;
  localparam int POS_IRQ_LOW = 1;
  // Reset values
  localparam logic [2:0] RST_THR = 3'h0;
  localparam logic RST_BIT = 1'b0;
  localparam logic [5:0] RST_WIN = 6'h3f;
  localparam logic [3:0] RST_PSC = 4'h0;
  localparam logic [1:0] RST_IRQ = 2'h0;
  // Prescale codes with fixed, non-power-of-two or large ratios
  localparam logic [3:0] PSC_FIRST_DIV = 4'h2;
  localparam logic [3:0] PSC_2048 = 4'hc;
  localparam logic [3:0] PSC_4096 = 4'hd;
  localparam logic [3:0] PSC_10240 = 4'he;
  localparam logic [3:0] PSC_61440 = 4'hf;
  localparam logic [15:0] DIV_2048 = 16'h0800;
  localparam logic [15:0] DIV_4096 = 16'h1000;
  localparam logic [15:0] DIV_10240 = 16'h2800;
  localparam logic [15:0] DIV_61440 = 16'hf000;
  // Nominal time base rate in kHz, for reference by software models
  localparam int LSI_KHZ = 128;

  typedef enum logic [2:0] {
    ST_RUN = 3'h1,
    ST_STANDBY = 3'h2,
    ST_RESET = 3'h4
  } pwrwk_mode_t;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic we;
    logic re;
  } pwrwk_req_t;

  typedef struct packed {
    logic standby;
    logic sys_reset_req;
    logic fast_osc_sel;
    logic wake_pulse;
  } pwrwk_pm_t;
endpackage
`default_nettype wire

/* File: hdl/pwrwk_top.sv */
`timescale 1ns/10ps
`default_nettype none
module pwrwk_top #(
  parameter int PRE_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire pwrwk_pkg::pwrwk_req_t req_i,
  output logic [31:0] rdata_o,
  // Oscillator and analog
  input wire logic lsi_clk_i,
  input wire logic supply_below_i,
  output logic supply_monitor_on_o,
  output logic [2:0] threshold_select_o,
  // Core and option byte
  input wire logic core_deep_sleep_i,
  input wire logic sleep_req_i,
  input wire logic ext_wake_i,
  input wire logic standby_reset_opt_i,
  output pwrwk_pkg::pwrwk_pm_t pm_o,
  // Interrupt
  output logic irq_o
);
  typedef struct packed {
    logic [2:0] lsi_sync;
    logic lsi_lvl;
    logic [2:0] sup_sync;
    logic sup_lvl;
    logic [2:0] thr;
    logic mon_en;
    logic dds;
    logic flag;
    logic wk_en;
    logic [5:0] win;
    logic [3:0] psc;
    logic [PRE_W-1:0] pre_cnt;
    logic [5:0] wk_cnt;
    logic [1:0] ist;
    logic [1:0] ien;
    logic [31:0] rdata;
    pwrwk_pkg::pwrwk_mode_t mode;
    logic rst_req;
    logic fast_sel;
    logic wake;
  } pwrwk_state_t;

  pwrwk_state_t s_q;
  pwrwk_state_t s_d;

  if (PRE_W < 16) begin : g_chk
    $error("PRE_W must hold a count of 61440");
  end

  // Divide ratio for a prescale code; codes 0 and 1 pass every tick
  function automatic logic [PRE_W-1:0] div_of(input logic [3:0] code);
    logic [15:0] r;
    r = 16'h0001;
    if (code == pwrwk_pkg::PSC_2048) begin
      r = pwrwk_pkg::DIV_2048;
    end else if (code == pwrwk_pkg::PSC_4096) begin
      r = pwrwk_pkg::DIV_4096;
    end else if (code == pwrwk_pkg::PSC_10240) begin
      r = pwrwk_pkg::DIV_10240;
    end else if (code == pwrwk_pkg::PSC_61440) begin
      r = pwrwk_pkg::DIV_61440;
    end else if (code >= pwrwk_pkg::PSC_FIRST_DIV) begin
      r = 16'h0001 << (code - 4'h1);
    end
    return PRE_W'(r);
  endfunction

  logic lsi_tick;
  logic wk_tick;
  logic wk_match;
  logic low_rise;
  logic enter;
  logic woke;
  logic [PRE_W-1:0] div;

  always_comb begin
    s_d = s_q;
    s_d.rst_req = 1'b0;
    s_d.fast_sel = 1'b0;
    s_d.wake = 1'b0;
    s_d.rdata = 32'h0;
    // Oscillator and detector inputs: three stages, change taken when last two agree
    s_d.lsi_sync = {s_q.lsi_sync[1:0], lsi_clk_i};
    s_d.sup_sync = {s_q.sup_sync[1:0], supply_below_i};
    if (s_q.lsi_sync[1] == s_q.lsi_sync[2]) begin
      s_d.lsi_lvl = s_q.lsi_sync[2];
    end
    if (s_q.sup_sync[1] == s_q.sup_sync[2]) begin
      s_d.sup_lvl = s_q.sup_sync[2];
    end
    // One tick per rising edge of the slow oscillator
    lsi_tick = s_d.lsi_lvl & ~s_q.lsi_lvl;
    // Flag follows the detector only while monitoring; otherwise it holds 0
    s_d.flag = s_q.mon_en & s_q.sup_lvl;
    low_rise = s_d.flag & ~s_q.flag;

    div = div_of(s_q.psc);
    wk_tick = 1'b0;
    wk_match = 1'b0;
    if (!s_q.wk_en) begin
      s_d.pre_cnt = '0;
      s_d.wk_cnt = 6'h0;
    end else if (lsi_tick) begin
      if (s_q.pre_cnt >= div - PRE_W'(1)) begin
        s_d.pre_cnt = '0;
        wk_tick = 1'b1;
      end else begin
        s_d.pre_cnt = s_q.pre_cnt + PRE_W'(1);
      end
    end
    if (wk_tick) begin
      if (s_q.wk_cnt == s_q.win) begin
        wk_match = 1'b1;
        s_d.wk_cnt = 6'h0;
      end else begin
        s_d.wk_cnt = s_q.wk_cnt + 6'h1;
      end
    end
    s_d.wake = wk_match;

    // Standby sequencing; core signals software's deep sleep choice
    enter = sleep_req_i & core_deep_sleep_i & s_q.dds;
    woke = 1'b0;
    case (s_q.mode)
      pwrwk_pkg::ST_RUN: begin
        if (enter && standby_reset_opt_i) begin
          s_d.mode = pwrwk_pkg::ST_RESET;
          s_d.rst_req = 1'b1;
        end else if (enter) begin
          s_d.mode = pwrwk_pkg::ST_STANDBY;
        end
      end
      pwrwk_pkg::ST_STANDBY: begin
        if (wk_match || ext_wake_i) begin
          s_d.mode = pwrwk_pkg::ST_RUN;
          s_d.fast_sel = 1'b1;
          woke = 1'b1;
        end
      end
      pwrwk_pkg::ST_RESET: begin
        // Held until the system reset returns the block to run state
        s_d.rst_req = 1'b1;
      end
      default: begin
        s_d.mode = pwrwk_pkg::ST_RUN;
      end
    endcase
    // Control register reinitialises on wake; status and timer keep their values
    if (woke) begin
      s_d.thr = pwrwk_pkg::RST_THR;
      s_d.mon_en = pwrwk_pkg::RST_BIT;
      s_d.dds = pwrwk_pkg::RST_BIT;
    end

    // Register writes
    if (req_i.we) begin
      if (req_i.addr == pwrwk_pkg::OFS_CTRL) begin
        s_d.thr = req_i.wdata[pwrwk_pkg::POS_THR +: 3];
        s_d.mon_en = req_i.wdata[pwrwk_pkg::POS_MON_EN];
        s_d.dds = req_i.wdata[pwrwk_pkg::POS_DDS];
      end else if (req_i.addr == pwrwk_pkg::OFS_WKCTL) begin
        s_d.wk_en = req_i.wdata[pwrwk_pkg::POS_WK_EN];
      end else if (req_i.addr == pwrwk_pkg::OFS_WIN) begin
        s_d.win = req_i.wdata[5:0];
      end else if (req_i.addr == pwrwk_pkg::OFS_PSC) begin
        s_d.psc = req_i.wdata[3:0];
      end else if (req_i.addr == pwrwk_pkg::OFS_IRQ_CLR) begin
        s_d.ist = s_q.ist & ~req_i.wdata[1:0];
      end else if (req_i.addr == pwrwk_pkg::OFS_IRQ_EN) begin
        s_d.ien = req_i.wdata[1:0];
      end
    end
    // Events set after the clear so a coincident event is kept
    if (wk_match) begin
      s_d.ist[pwrwk_pkg::POS_IRQ_WAKE] = 1'b1;
    end
    if (low_rise) begin
      s_d.ist[pwrwk_pkg::POS_IRQ_LOW] = 1'b1;
    end

    // Register reads; unmapped and write-only offsets read zero
    if (req_i.re) begin
      if (req_i.addr == pwrwk_pkg::OFS_CTRL) begin
        s_d.rdata[pwrwk_pkg::POS_THR +: 3] = s_q.thr;
        s_d.rdata[pwrwk_pkg::POS_MON_EN] = s_q.mon_en;
        s_d.rdata[pwrwk_pkg::POS_DDS] = s_q.dds;
      end else if (req_i.addr == pwrwk_pkg::OFS_STAT) begin
        s_d.rdata[pwrwk_pkg::POS_FLAG] = s_q.flag;
      end else if (req_i.addr == pwrwk_pkg::OFS_WKCTL) begin
        s_d.rdata[pwrwk_pkg::POS_WK_EN] = s_q.wk_en;
      end else if (req_i.addr == pwrwk_pkg::OFS_WIN) begin
        s_d.rdata[5:0] = s_q.win;
      end else if (req_i.addr == pwrwk_pkg::OFS_PSC) begin
        s_d.rdata[3:0] = s_q.psc;
      end else if (req_i.addr == pwrwk_pkg::OFS_IRQ_ST) begin
        s_d.rdata[1:0] = s_q.ist;
      end else if (req_i.addr == pwrwk_pkg::OFS_IRQ_EN) begin
        s_d.rdata[1:0] = s_q.ien;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s_q.lsi_sync <= 3'h0;
      s_q.lsi_lvl <= 1'b0;
      s_q.sup_sync <= 3'h0;
      s_q.sup_lvl <= 1'b0;
      s_q.thr <= pwrwk_pkg::RST_THR;
      s_q.mon_en <= pwrwk_pkg::RST_BIT;
      s_q.dds <= pwrwk_pkg::RST_BIT;
      s_q.flag <= pwrwk_pkg::RST_BIT;
      s_q.wk_en <= pwrwk_pkg::RST_BIT;
      s_q.win <= pwrwk_pkg::RST_WIN;
      s_q.psc <= pwrwk_pkg::RST_PSC;
      s_q.pre_cnt <= '0;
      s_q.wk_cnt <= 6'h0;
      s_q.ist <= pwrwk_pkg::RST_IRQ;
      s_q.ien <= pwrwk_pkg::RST_IRQ;
      s_q.rdata <= 32'h0;
      s_q.mode <= pwrwk_pkg::ST_RUN;
      s_q.rst_req <= 1'b0;
      s_q.fast_sel <= 1'b0;
      s_q.wake <= 1'b0;
    end else begin
      s_q <= s_d;
    end
  end

  assign rdata_o = s_q.rdata;
  assign supply_monitor_on_o = s_q.mon_en;
  assign threshold_select_o = s_q.thr;
  assign pm_o.standby = (s_q.mode == pwrwk_pkg::ST_STANDBY);
  assign pm_o.sys_reset_req = s_q.rst_req;
  assign pm_o.fast_osc_sel = s_q.fast_sel;
  assign pm_o.wake_pulse = s_q.wake;
  assign irq_o = |(s_q.ist & s_q.ien);
endmodule
`default_nettype wire

/* File: bench/pwrwk_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module pwrwk_properties (
  // Watched ports
  input wire logic clk_i,
  input wire logic rst_i,
  input wire pwrwk_pkg::pwrwk_req_t req_i,
  input wire logic [31:0] rdata_o,
  input wire logic supply_monitor_on_o,
  input wire logic sleep_req_i,
  input wire logic core_deep_sleep_i,
  input wire logic standby_reset_opt_i,
  input wire pwrwk_pkg::pwrwk_pm_t pm_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic rs, go;
  assign rs = req_i.re && req_i.addr == pwrwk_pkg::OFS_STAT;
  assign go = sleep_req_i && core_deep_sleep_i;
  property p_mon; req_i.we && req_i.addr == pwrwk_pkg::OFS_CTRL |=> supply_monitor_on_o == $past(req_i.wdata[4]); endproperty
  a_mon: assert property (p_mon) else $error("mon");
  property p_off; rs && !supply_monitor_on_o && !$past(supply_monitor_on_o) |=> !rdata_o[2]; endproperty
  a_off: assert property (p_off) else $error("flag");
  property p_rsv; rs |=> rdata_o[31:3] == 0 && rdata_o[1:0] == 0; endproperty
  a_rsv: assert property (p_rsv) else $error("rsv");
  property p_sby; $rose(pm_o.standby) |-> $past(go) && !$past(standby_reset_opt_i); endproperty
  a_sby: assert property (p_sby) else $error("sby");
  property p_rst; $rose(pm_o.sys_reset_req) |-> $past(go) && $past(standby_reset_opt_i); endproperty
  a_rst: assert property (p_rst) else $error("rst");
  property p_exc; !(pm_o.standby && pm_o.sys_reset_req); endproperty
  a_exc: assert property (p_exc) else $error("exc");
  property p_fast; pm_o.fast_osc_sel == $fell(pm_o.standby); endproperty
  a_fast: assert property (p_fast) else $error("fast");
  property p_wk; pm_o.wake_pulse |=> !pm_o.wake_pulse; endproperty
  a_wk: assert property (p_wk) else $error("wake");
  c_wk: cover property (pm_o.wake_pulse);
  c_sby: cover property ($rose(pm_o.standby));
  c_rst: cover property ($rose(pm_o.sys_reset_req));
endmodule
bind pwrwk_top pwrwk_properties u_chk (.clk_i(clk_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .supply_monitor_on_o(supply_monitor_on_o), .sleep_req_i(sleep_req_i), .core_deep_sleep_i(core_deep_sleep_i),
  .standby_reset_opt_i(standby_reset_opt_i), .pm_o(pm_o));
`default_nettype wire

/* File: bench/tb_pwrwk_top.sv */
`timescale 1ns/10ps
`default_nettype none
module tb_pwrwk_top;
  logic clk_i, rst_i, low_speed_internal_osc, below, cds, slp, opt, mon, irq, ewk;
  logic [2:0] thr;
  logic [31:0] rd;
  pwrwk_pkg::pwrwk_req_t q;
  pwrwk_pkg::pwrwk_pm_t pm;
  int mismatches, tests_run, edges, e0;
  pwrwk_top DUT (.clk_i(clk_i), .rst_i(rst_i), .req_i(q), .rdata_o(rd), .lsi_clk_i(low_speed_internal_osc), .supply_below_i(below),
    .supply_monitor_on_o(mon), .threshold_select_o(thr), .core_deep_sleep_i(cds), .sleep_req_i(slp),
    .ext_wake_i(ewk), .standby_reset_opt_i(opt), .pm_o(pm), .irq_o(irq));
  initial begin
    clk_i = 0;
    forever #12.5 clk_i = ~clk_i;
  end
  // Time base of 8 cycles so divides up to 2048 fit the run
  initial begin
    low_speed_internal_osc = 0;
    forever #100 low_speed_internal_osc = ~low_speed_internal_osc;
  end
  always @(posedge low_speed_internal_osc) edges++;
  task chk(input string n, input logic [31:0] s, e);
    tests_run++;
    if (s !== e) begin
      mismatches++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    q <= '{a, d, 1'b1, 1'b0};
    @(posedge clk_i);
    q.we <= 0;
  endtask
  task rc(input string n, input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    q <= '{a, 32'h0, 1'b0, 1'b1};
    @(posedge clk_i);
    q.re <= 0;
    @(negedge clk_i);
    chk(n, rd, e);
  endtask
  task wt(input int lim);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      #1 n++;
    end while (pm.wake_pulse !== 1 && n < lim);
  endtask
  task per(input string n, input logic [31:0] e);
    wt(20000);
    e0 = edges;
    wt(20000);
    chk(n, 32'(edges - e0), e);
  endtask
  task nap();
    repeat (3) @(negedge clk_i);
  endtask
  task doze();
    @(posedge clk_i);
    slp <= 1;
    @(posedge clk_i);
    slp <= 0;
    nap();
  endtask
  task t_regs();
    for (int i = 0; i < 9; i++) begin
      rc("reset", 8'(4 * i), (i == 3) ? 32'h3f : 32'h0);
    end
    wr(8'h08, 32'hffff_ffff);
    rc("wake ctl", 8'h08, 32'h2);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h10);
    @(posedge clk_i);
    below <= 1;
    repeat (8) @(posedge clk_i);
    rc("flag", 8'h04, 32'h4);
    wr(8'h00, 32'he0);
    rc("ctrl", 8'h00, 32'he0);
    chk("thr", 32'(thr), 32'h7);
    wr(8'h00, 32'h0);
    repeat (8) @(posedge clk_i);
    rc("flag off", 8'h04, 32'h0);
    chk("mon", 32'(mon), 32'h0);
  endtask
  task t_div();
    wr(8'h0c, 32'h0);
    for (int c = 0; c < 13; c++) begin
      wr(8'h10, 32'(c));
      wr(8'h08, 32'h2);
      per("period", c < 2 ? 32'h1 : c < 12 ? 32'h1 << (c - 1) : 32'h800);
      wr(8'h08, 32'h0);
    end
    wr(8'h10, 32'h0);
    wt(40);
    chk("idle", 32'(pm.wake_pulse), 32'h0);
    wr(8'h0c, 32'h3);
    wr(8'h10, 32'h2);
    wr(8'h08, 32'h2);
    per("window", 32'h8);
  endtask
  task t_irq();
    wr(8'h18, 32'h3);
    wr(8'h1c, 32'h1);
    wt(500);
    wr(8'h08, 32'h0);
    rc("irq st", 8'h14, 32'h1);
    chk("irq", 32'(irq), 32'h1);
    wr(8'h1c, 32'h0);
    nap();
    chk("masked", 32'(irq), 32'h0);
    wr(8'h1c, 32'h1);
    wr(8'h18, 32'h1);
    nap();
    chk("cleared", 32'(irq), 32'h0);
  endtask
  task t_sby();
    wr(8'h00, 32'h2);
    @(posedge clk_i);
    cds <= 1;
    doze();
    chk("standby", 32'(pm.standby), 32'h1);
    wr(8'h08, 32'h2);
    wt(500);
    nap();
    chk("woken", 32'(pm.standby), 32'h0);
    wr(8'h08, 32'h0);
    wr(8'h00, 32'h0);
    doze();
    chk("no entry", 32'(pm.standby), 32'h0);
    wr(8'h00, 32'h2);
    doze();
    chk("standby 2", 32'(pm.standby), 32'h1);
    @(posedge clk_i);
    ewk <= 1;
    @(posedge clk_i);
    ewk <= 0;
    nap();
    chk("ext woken", 32'(pm.standby), 32'h0);
    wr(8'h00, 32'h2);
    @(posedge clk_i);
    opt <= 1;
    doze();
    chk("reset req", 32'(pm.sys_reset_req), 32'h1);
    @(posedge clk_i);
    rst_i <= 1;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    nap();
    chk("reset done", 32'(pm.sys_reset_req), 32'h0);
  endtask
  initial begin
    q = '0;
    ewk = 0;
    {rst_i, below, cds, slp, opt} = 5'h10;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    t_regs();
    t_div();
    t_irq();
    t_sby();
    wrap_up();
  end
  initial begin
    repeat (90000) @(posedge clk_i);
    mismatches++;
    wrap_up();
  end
  task wrap_up();
    if (mismatches == 0 && tests_run > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
endmodule
`default_nettype wire
